/* hw/encoder_count_core.sv */
// Four-channel encoder counting core with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "encoder_count_consts.svh"
module encoder_count_core import encoder_count_pkg::*; #(
  parameter int unsigned N_CNT = `N_COUNTERS,
  parameter int unsigned N_IDX = `N_INDEXED,
  parameter int unsigned W = `CNT_W,
  parameter int unsigned TB_DIV = `TIMEBASE_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder pins
  input wire logic [N_CNT-1:0] enc_a,
  input wire logic [N_CNT-1:0] enc_b,
  input wire logic [N_IDX-1:0] enc_index,
  // Fault summary
  output logic general_fault_flag
);

  localparam int unsigned TBW = (TB_DIV > 1) ? $clog2(TB_DIV) : 1;

  ////////////////////////////////////////////////////////////////////
  // APB decode

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic gf_ff;
  logic [3:0] pg;
  logic [1:0] ci;
  logic [3:0] ri;
  logic glb_hit;
  logic cnt_hit;
  logic wr_en;
  logic [31:0] rd_data;
  logic [31:0] rd_word_a [N_CNT];
  logic [N_CNT-1:0] lor_a;

  assign pg = paddr[11:8];
  assign ci = paddr[7:6];
  assign ri = paddr[5:2];
  assign glb_hit = (paddr[1:0] == 2'h0) && (pg == `GLB_PAGE) &&
                   (paddr[7:6] == 2'h0) && (ri <= `R_GSTS);
  assign cnt_hit = (paddr[1:0] == 2'h0) && (pg == `CNT_PAGE) &&
                   (32'(ci) < N_CNT) && (ri <= `R_STS);
  assign wr_en = psel & penable & pwrite & pready_ff;

  ////////////////////////////////////////////////////////////////////
  // Global control and clear sequence

  logic [3:0] gctl_ff;
  logic run_prev_ff;
  logic inh_prev_ff;
  clr_state_e clr_ff;
  logic clr_go;
  logic clr_hold;
  logic wr_gctl;

  assign wr_gctl = wr_en & glb_hit & (ri == `R_GCTL);
  assign clr_go = gctl_ff[`GC_CLEAR] &
                  ((gctl_ff[`GC_RUN] & ~run_prev_ff) |
                   (~gctl_ff[`GC_INHIBIT] & inh_prev_ff));
  assign clr_hold = clr_go | (clr_ff == CLR_HOLD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctl_ff <= `GCTL_RST;
    end else begin
      if (wr_gctl) begin
        gctl_ff <= pwdata[3:0];
      end
      if (clr_go) begin
        gctl_ff[`GC_APPLIED] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev_ff <= 1'b0;
      inh_prev_ff <= 1'b1;
    end else begin
      run_prev_ff <= gctl_ff[`GC_RUN];
      inh_prev_ff <= gctl_ff[`GC_INHIBIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_ff <= CLR_IDLE;
    end else begin
      case (clr_ff)
        CLR_IDLE: begin
          if (clr_go) begin
            clr_ff <= CLR_HOLD;
          end
        end
        CLR_HOLD: begin
          if (gctl_ff[`GC_APPLIED]) begin
            clr_ff <= CLR_IDLE;
          end
        end
        default: begin
          clr_ff <= CLR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // 1 MHz timebase

  logic [TBW-1:0] tb_cnt_ff;
  logic tick_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tb_cnt_ff == TBW'(TB_DIV - 1)) begin
      tb_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + TBW'(1);
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-counter datapath

  for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
    localparam bit HAS_IDX = (i < N_IDX);

    cnt_cfg_s cfg_ff;
    cnt_ctl_s ctl_ff;
    cnt_sts_s sts_ff;
    logic signed [W-1:0] upper_ff;
    logic signed [W-1:0] lower_ff;
    logic signed [W-1:0] load_ff;
    logic signed [W-1:0] ovw_ff;
    logic signed [W-1:0] cnt_ff;
    logic signed [W-1:0] cap_ff;
    logic signed [W-1:0] cnt_step;
    logic [W-1:0] spacing;
    logic sw_prev_ff;
    logic ovw_prev_ff;
    logic idx_prev_ff;
    logic idx_pin;
    logic idx_sync;
    logic up;
    logic dn;
    logic eidx;
    logic idx_rise;
    logic z_store;
    logic z_preset;
    logic z_hold;
    logic soft_rise;
    logic ovw_rise;
    logic preset;
    logic oor;
    logic zero_ok;
    logic load_any;
    logic step_ok;
    logic set_over;
    logic set_under;
    logic wsel;
    logic [3:0] w1c;

    if (HAS_IDX) begin : g_idx
      assign idx_pin = enc_index[i];
    end else begin : g_noidx
      assign idx_pin = 1'b0;
    end

    quad_edge_decoder u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .pin_a(enc_a[i]),
      .pin_b(enc_b[i]),
      .pin_idx(idx_pin),
      .mode(cfg_ff.mode),
      .step_up(up),
      .step_dn(dn),
      .idx_level(idx_sync)
    );

    pulse_spacing_timer #(.W(W)) u_space (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_ff),
      .pulse(up | dn),
      .clear(clr_go),
      .spacing(spacing)
    );

    assign wsel = wr_en & cnt_hit & (ci == 2'(i));
    assign w1c = (wsel && ri == `R_STS) ? pwdata[3:0] : 4'h0;

    // Index path exists only where a pin does
    assign eidx = HAS_IDX &&
      (ctl_ff.index_suppress ? ctl_ff.index_polarity_flip
                             : (idx_sync ^ ctl_ff.index_polarity_flip));
    assign idx_rise = eidx & ~idx_prev_ff;
    assign z_store = cfg_ff.idx_store & idx_rise;
    assign z_preset = cfg_ff.idx_preset & idx_rise;
    assign z_hold = cfg_ff.idx_hold & eidx;

    assign soft_rise = ctl_ff.software_load_request & ~sw_prev_ff;
    assign ovw_rise = ctl_ff.overwrite_strobe & ~ovw_prev_ff;
    assign preset = soft_rise | z_preset;
    assign oor = (upper_ff < cnt_ff) | (lower_ff > cnt_ff);
    assign zero_ok = (upper_ff >= 0) && (lower_ff <= 0);
    assign load_any = preset | ovw_rise | oor;
    assign step_ok = ctl_ff.counter_run_enable & ~z_hold & (up ^ dn);

    always_comb begin
      cnt_step = cnt_ff;
      set_over = 1'b0;
      set_under = 1'b0;
      if (step_ok && up) begin
        if (cnt_ff >= upper_ff) begin
          set_over = 1'b1;
          cnt_step = cfg_ff.ring ? lower_ff : cnt_ff;
        end else begin
          cnt_step = cnt_ff + W'(1);
        end
      end else if (step_ok && dn) begin
        if (cnt_ff <= lower_ff) begin
          set_under = 1'b1;
          cnt_step = cfg_ff.ring ? upper_ff : cnt_ff;
        end else begin
          cnt_step = cnt_ff - W'(1);
        end
      end
    end

    // Configuration words
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_ff <= '0;
        upper_ff <= `UPPER_RST;
        lower_ff <= `LOWER_RST;
        load_ff <= '0;
        ovw_ff <= '0;
      end else if (wsel) begin
        case (ri)
          `R_CFG: cfg_ff <= cnt_cfg_s'(pwdata[$bits(cnt_cfg_s)-1:0]);
          `R_UPPER: upper_ff <= $signed(pwdata[W-1:0]);
          `R_LOWER: lower_ff <= $signed(pwdata[W-1:0]);
          `R_LOAD: load_ff <= $signed(pwdata[W-1:0]);
          `R_OVW: ovw_ff <= $signed(pwdata[W-1:0]);
          default: ;
        endcase
      end
    end

    // Control array, held at zero through a global clear
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_ff <= '0;
      end else if (clr_hold) begin
        ctl_ff <= '0;
      end else if (wsel && ri == `R_CTL) begin
        ctl_ff <= cnt_ctl_s'(pwdata[$bits(cnt_ctl_s)-1:0]);
      end
    end

    // Edge history; cleared so stale host bits act as new edges
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sw_prev_ff <= 1'b0;
        ovw_prev_ff <= 1'b0;
        idx_prev_ff <= 1'b0;
      end else begin
        sw_prev_ff <= ctl_ff.software_load_request;
        ovw_prev_ff <= ctl_ff.overwrite_strobe;
        idx_prev_ff <= eidx;
      end
    end

    // Count register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff <= '0;
      end else if (clr_go) begin
        cnt_ff <= zero_ok ? '0 : load_ff;
      end else if (preset) begin
        cnt_ff <= load_ff;
      end else if (ovw_rise) begin
        cnt_ff <= ovw_ff;
      end else if (oor) begin
        cnt_ff <= load_ff;
      end else begin
        cnt_ff <= cnt_step;
      end
    end

    // Captured count, taken before any preset on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cap_ff <= '0;
      end else if (clr_go) begin
        cap_ff <= '0;
      end else if (z_store) begin
        cap_ff <= cnt_ff;
      end
    end

    // Status flags; a set beats a flag clear in the same cycle, a global clear beats a set
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sts_ff <= '0;
      end else if (clr_go) begin
        sts_ff <= '0;
        sts_ff.load_out_of_range_flag <= ~zero_ok;
      end else begin
        sts_ff.over <= (sts_ff.over & ~ctl_ff.clear_over_limit_flag) |
                       (set_over & ~load_any);
        sts_ff.under <= (sts_ff.under & ~ctl_ff.clear_under_limit_flag) |
                        (set_under & ~load_any);
        sts_ff.index_edge_seen <= (sts_ff.index_edge_seen & ~w1c[2]) | idx_rise;
        sts_ff.load_out_of_range_flag <= (sts_ff.load_out_of_range_flag & ~w1c[3]) |
                                         oor | (preset & ~zero_ok);
      end
    end

    assign lor_a[i] = sts_ff.load_out_of_range_flag;

    always_comb begin
      rd_word_a[i] = 32'h0;
      case (ri)
        `R_CFG: rd_word_a[i] = 32'(cfg_ff);
        `R_UPPER: rd_word_a[i] = 32'(upper_ff);
        `R_LOWER: rd_word_a[i] = 32'(lower_ff);
        `R_LOAD: rd_word_a[i] = 32'(load_ff);
        `R_CTL: rd_word_a[i] = 32'(ctl_ff);
        `R_OVW: rd_word_a[i] = 32'(ovw_ff);
        `R_COUNT: rd_word_a[i] = 32'(cnt_ff);
        `R_CAPT: rd_word_a[i] = 32'(cap_ff);
        `R_SPACE: rd_word_a[i] = 32'(spacing);
        `R_STS: rd_word_a[i] = 32'(sts_ff);
        default: rd_word_a[i] = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux and APB answer

  always_comb begin
    rd_data = 32'h0;
    if (glb_hit) begin
      if (ri == `R_GCTL) begin
        rd_data = {28'h0, gctl_ff};
      end else begin
        rd_data = {30'h0, clr_ff == CLR_HOLD, gf_ff};
      end
    end else if (cnt_hit) begin
      rd_data = rd_word_a[ci];
    end
  end

  // Answer comes one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~(glb_hit | cnt_hit);
      if (psel && !penable) begin
        prdata_ff <= pwrite ? 32'h0 : rd_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gf_ff <= 1'b0;
    end else begin
      gf_ff <= |lor_a;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign general_fault_flag = gf_ff;

endmodule : encoder_count_core
`default_nettype wire

/* hw/encoder_count_consts.svh */
// Constants, register map and timing for the encoder counting core
// Function
// - Count at 250k x4, 500k x2, else 1MHz
// - Four counters, each linear or ring between limits
// - Linear count stays in limits, flags on excess
// - Clear bits clear overflow and underflow flags
// - Pinned linear counter moves on first reverse pulse
// - Ring up at upper loads lower, overflow
// - Ring down at lower loads upper, underflow
// - Index store, hold and preset functions
// - Store captures before preset on same edge
// - Index functions only on counters 0 and 1
// - Run enable gates counting, not loads
// - Index invert; suppress uses invert bit as index
// - Overwrite strobe rising edge loads overwrite value
// - Preset beats simultaneous overwrite
// - Global clear disables counters and zeroes counts
// - Control array held zero until configuration applied
// - Global clear resets flags and count values
// - Software load request loads load value
// - Zero out of limits loads load value, warns
// - Count outside limits forces load, warns
// - 1 MHz timer measures last pulse spacing
`ifndef ENCODER_COUNT_CONSTS_SVH
`define ENCODER_COUNT_CONSTS_SVH

`define N_COUNTERS 4
`define N_INDEXED 2
`define CNT_W 32
`define PCLK_PERIOD_NS 10
`define TIMEBASE_PERIOD_NS 1000
`define TIMEBASE_DIV (`TIMEBASE_PERIOD_NS / `PCLK_PERIOD_NS)

`define ADDR_W 12
`define GLB_PAGE 4'h0
`define CNT_PAGE 4'h1
`define R_GCTL 4'h0
`define R_GSTS 4'h1
`define R_CFG 4'h0
`define R_UPPER 4'h1
`define R_LOWER 4'h2
`define R_LOAD 4'h3
`define R_CTL 4'h4
`define R_OVW 4'h5
`define R_COUNT 4'h6
`define R_CAPT 4'h7
`define R_SPACE 4'h8
`define R_STS 4'h9

`define GC_CLEAR 0
`define GC_INHIBIT 1
`define GC_APPLIED 2
`define GC_RUN 3
`define GCTL_RST 4'h2
`define UPPER_RST 32'h7fffffff
`define LOWER_RST 32'h80000000

`endif

/* hw/encoder_count_pkg.sv */
// Types shared by the encoder counting core
`default_nettype none
package encoder_count_pkg;

  typedef enum logic [2:0] {
    MODE_UPDN = 3'h0,
    MODE_PDIR = 3'h1,
    MODE_QX1 = 3'h2,
    MODE_QX2 = 3'h3,
    MODE_QX4 = 3'h4
  } in_mode_e;

  typedef struct packed {
    logic idx_preset;
    logic idx_hold;
    logic idx_store;
    logic ring;
    in_mode_e mode;
  } cnt_cfg_s;

  typedef struct packed {
    logic overwrite_strobe;
    logic index_suppress;
    logic index_polarity_flip;
    logic clear_under_limit_flag;
    logic clear_over_limit_flag;
    logic software_load_request;
    logic counter_run_enable;
  } cnt_ctl_s;

  typedef struct packed {
    logic load_out_of_range_flag;
    logic index_edge_seen;
    logic under;
    logic over;
  } cnt_sts_s;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_HOLD = 2'b10
  } clr_state_e;

endpackage : encoder_count_pkg
`default_nettype wire

/* hw/quad_edge_decoder.sv */
// Pin synchroniser and count-step decoder for one channel
`timescale 1ns/1ps
`default_nettype none
module quad_edge_decoder import encoder_count_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_idx,
  // Mode and results
  input wire in_mode_e mode,
  output logic step_up,
  output logic step_dn,
  output logic idx_level
);

  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] prev_ff;
  logic a, b, ap, bp, ach, bch;

  // 10 ns sampling leaves margin at the fastest input rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      s1_ff <= {pin_a, pin_b, pin_idx};
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  assign a = s2_ff[2];
  assign b = s2_ff[1];
  assign ap = prev_ff[2];
  assign bp = prev_ff[1];
  assign ach = a ^ ap;
  assign bch = b ^ bp;
  assign idx_level = s2_ff[0];

  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (mode)
      MODE_UPDN: begin
        step_up = a & ~ap;
        step_dn = b & ~bp;
      end
      MODE_PDIR: begin
        step_up = a & ~ap & ~b;
        step_dn = a & ~ap & b;
      end
      MODE_QX1: begin
        step_up = a & ~ap & ~b;
        step_dn = a & ~ap & b;
      end
      MODE_QX2: begin
        step_up = ach & (a ^ b);
        step_dn = ach & ~(a ^ b);
      end
      MODE_QX4: begin
        // Both phases moving at once is illegal and ignored
        step_up = (ach ^ bch) & ~(ap ^ b);
        step_dn = (ach ^ bch) & (ap ^ b);
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

endmodule : quad_edge_decoder
`default_nettype wire

/* hw/pulse_spacing_timer.sv */
// Interval between successive input pulses in timebase ticks
`timescale 1ns/1ps
`default_nettype none
module pulse_spacing_timer #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events
  input wire logic tick,
  input wire logic pulse,
  input wire logic clear,
  // Result
  output logic [W-1:0] spacing
);

  logic [W-1:0] run_ff;
  logic [W-1:0] spacing_ff;
  logic seen_ff;

  // Only the latest pulse pair is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= '0;
      spacing_ff <= '0;
      seen_ff <= 1'b0;
    end else if (clear) begin
      run_ff <= '0;
      spacing_ff <= '0;
      seen_ff <= 1'b0;
    end else if (pulse) begin
      if (seen_ff) begin
        spacing_ff <= run_ff;
      end
      run_ff <= '0;
      seen_ff <= 1'b1;
    end else if (tick && !(&run_ff)) begin
      run_ff <= run_ff + W'(1);
    end
  end

  assign spacing = spacing_ff;

endmodule : pulse_spacing_timer
`default_nettype wire

/* tb/encoder_count_core_monitor.sv */
// APB answer and fault flag checker for the encoder counting core
`timescale 1ns/1ps
`default_nettype none
`include "encoder_count_consts.svh"
module encoder_count_core_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fault summary
  input wire logic general_fault_flag
);
  logic [3:0] since_wr_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last completed write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wr_ff <= 4'hf;
    end else if (psel && penable && pready && pwrite) begin
      since_wr_ff <= 4'h0;
    end else if (since_wr_ff != 4'hf) begin
      since_wr_ff <= since_wr_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup cycle without answer");
  ready_single_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error outside answer");
  misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("unaligned access not refused");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  fault_rise_a: assert property ($rose(general_fault_flag) |-> since_wr_ff <= 4'h6)
    else $error("fault raised without a preceding write");
  fault_fall_a: assert property ($fell(general_fault_flag) |-> since_wr_ff <= 4'h6)
    else $error("fault cleared without a preceding write");
  cover property (psel && penable && pready && pwrite);
  cover property (pslverr);
  cover property ($rose(general_fault_flag));
endmodule : encoder_count_core_monitor

bind encoder_count_core encoder_count_core_monitor encoder_count_core_monitor_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .general_fault_flag
);
`default_nettype wire

/* tb/enc_src.sv */
// Encoder and index pin source for the counting core
`timescale 1ns/1ps
`default_nettype none
module enc_src (
  // Clock
  input wire logic pclk,
  // Pins
  output logic [3:0] enc_a,
  output logic [3:0] enc_b,
  output logic [1:0] enc_index
);
  // Each level outlasts the two-stage synchroniser
  localparam int HOLD = 3;
  initial begin
    enc_a = 4'h0;
    enc_b = 4'h0;
    enc_index = 2'h0;
  end
  task automatic hold_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold_n
  // Forward quadrature cycles, A leading B
  task automatic quad(input int ch, input int k);
    for (int i = 0; i < 4 * k; i++) begin
      @(posedge pclk);
      enc_a[ch] <= enc_a[ch] ^ (i % 2 == 0);
      enc_b[ch] <= enc_b[ch] ^ (i % 2 == 1);
      hold_n(HOLD);
    end
  endtask : quad
  // Pulses on A for up, B for down; rise to rise is HOLD + gap + 1
  task automatic pulse(input int ch, input bit up, input int n, input int gap);
    repeat (n) begin
      @(posedge pclk);
      enc_a[ch] <= up;
      enc_b[ch] <= !up;
      hold_n(HOLD);
      enc_a[ch] <= 1'b0;
      enc_b[ch] <= 1'b0;
      hold_n(gap);
    end
  endtask : pulse
  task automatic index(input int ch, input bit v);
    @(posedge pclk);
    enc_index[ch] <= v;
    hold_n(HOLD);
  endtask : index
endmodule : enc_src
`default_nettype wire

/* tb/tb_encoder_count_core.sv */
// Self-checking bench for the encoder counting core
`timescale 1ns/1ps
`default_nettype none
`include "encoder_count_consts.svh"
module tb_encoder_count_core;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic general_fault_flag;
  logic [3:0] enc_a;
  logic [3:0] enc_b;
  logic [1:0] enc_index;
  int fail_count = 0;
  int tests_run = 0;
  int k;
  logic [7:0] rnd = 8'h5e;
  logic [31:0] q;
  logic [31:0] c0;
  logic e;
  always #5 pclk = ~pclk;
  encoder_count_core #(.TB_DIV(4)) encoder_count_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .general_fault_flag(general_fault_flag)
  );
  enc_src enc_src_inst (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [11:0] ra(input int ch, input logic [3:0] r);
    return 12'h100 + 12'(ch) * 12'h040 + {6'h0, r, 2'b00};
  endfunction : ra
  function automatic logic [31:0] mode_exp(input int m, input int n);
    case (m)
      0, 5: return 32'h0;
      1, 2: return 32'(n);
      3: return 32'(2 * n);
      default: return 32'(4 * n);
    endcase
  endfunction : mode_exp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input int ch, input logic [3:0] r, input logic [31:0] exp);
    apb(1'b0, ra(ch, r), 32'h0);
    chk(q, exp);
  endtask : rc
  task automatic ctl(input int ch, input logic [31:0] v);
    wr(ra(ch, `R_CTL), v);
  endtask : ctl
  task automatic w8();
    repeat (8) @(posedge pclk);
  endtask : w8
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(0, `R_UPPER, `UPPER_RST);
    rc(0, `R_LOWER, `LOWER_RST);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h102, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(12'h000, 32'hc);
    for (int m = 0; m < 6; m++) begin
      rnd = lfsr(rnd);
      k = 1 + int'(rnd[1:0]);
      wr(ra(2, `R_CFG), 32'(m));
      ctl(2, 32'h1);
      ctl(2, 32'h3);
      ctl(2, 32'h1);
      enc_src_inst.quad(2, k);
      w8();
      rc(2, `R_COUNT, mode_exp(m, k));
    end
    done("modes");
    wr(ra(0, `R_UPPER), 32'd5);
    wr(ra(0, `R_LOWER), 32'hfffffffd);
    ctl(0, 32'h1);
    rnd = lfsr(rnd);
    enc_src_inst.pulse(0, 1'b1, 6 + int'(rnd[2:0]), 3);
    w8();
    rc(0, `R_COUNT, 32'd5);
    rc(0, `R_STS, 32'h1);
    enc_src_inst.pulse(0, 1'b0, 1, 3);
    w8();
    rc(0, `R_COUNT, 32'd4);
    ctl(0, 32'h5);
    ctl(0, 32'h1);
    rc(0, `R_STS, 32'h0);
    enc_src_inst.pulse(0, 1'b0, 9, 3);
    w8();
    rc(0, `R_COUNT, 32'hfffffffd);
    rc(0, `R_STS, 32'h2);
    done("linear");
    wr(ra(0, `R_CFG), 32'h8);
    ctl(0, 32'h9);
    ctl(0, 32'h1);
    enc_src_inst.pulse(0, 1'b0, 1, 3);
    w8();
    rc(0, `R_COUNT, 32'd5);
    rc(0, `R_STS, 32'h2);
    enc_src_inst.pulse(0, 1'b1, 1, 3);
    w8();
    rc(0, `R_COUNT, 32'hfffffffd);
    rc(0, `R_STS, 32'h3);
    done("ring");
    ctl(0, 32'h0);
    enc_src_inst.pulse(0, 1'b1, 2, 3);
    w8();
    rc(0, `R_COUNT, 32'hfffffffd);
    wr(ra(0, `R_OVW), 32'd2);
    ctl(0, 32'h40);
    rc(0, `R_COUNT, 32'd2);
    ctl(0, 32'h0);
    wr(ra(0, `R_LOAD), 32'd1);
    ctl(0, 32'h42);
    rc(0, `R_COUNT, 32'd1);
    done("loads");
    wr(ra(0, `R_CFG), 32'h50);
    wr(ra(0, `R_LOAD), 32'd3);
    ctl(0, 32'h1);
    enc_src_inst.index(0, 1'b1);
    enc_src_inst.index(0, 1'b0);
    w8();
    rc(0, `R_CAPT, 32'd1);
    rc(0, `R_COUNT, 32'd3);
    wr(ra(0, `R_CFG), 32'h20);
    enc_src_inst.index(0, 1'b1);
    enc_src_inst.pulse(0, 1'b1, 2, 3);
    w8();
    rc(0, `R_COUNT, 32'd3);
    enc_src_inst.index(0, 1'b0);
    enc_src_inst.pulse(0, 1'b1, 1, 3);
    w8();
    rc(0, `R_COUNT, 32'd4);
    wr(ra(0, `R_CFG), 32'h10);
    ctl(0, 32'h21);
    ctl(0, 32'h31);
    w8();
    rc(0, `R_CAPT, 32'd4);
    rc(0, `R_STS, 32'h7);
    wr(ra(0, `R_STS), 32'h4);
    rc(0, `R_STS, 32'h3);
    apb(1'b0, ra(2, `R_COUNT), 32'h0);
    c0 = q;
    wr(ra(2, `R_CFG), 32'h50);
    wr(ra(2, `R_LOAD), 32'd9);
    ctl(2, 32'h20);
    ctl(2, 32'h30);
    w8();
    rc(2, `R_COUNT, c0);
    rc(2, `R_CAPT, 32'h0);
    done("index");
    for (int ch = 0; ch < 4; ch++) ctl(ch, 32'h0);
    wr(12'h000, 32'h3);
    wr(12'h000, 32'h1);
    w8();
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h2);
    rc(0, `R_COUNT, 32'h0);
    rc(0, `R_CAPT, 32'h0);
    rc(0, `R_STS, 32'h0);
    rc(0, `R_SPACE, 32'h0);
    ctl(0, 32'h1);
    rc(0, `R_CTL, 32'h0);
    wr(12'h000, 32'hc);
    ctl(0, 32'h1);
    rc(0, `R_CTL, 32'h1);
    done("clear");
    wr(ra(1, `R_LOAD), 32'd7);
    wr(ra(1, `R_LOWER), 32'd2);
    w8();
    rc(1, `R_COUNT, 32'd7);
    chk({31'h0, general_fault_flag}, 32'h1);
    wr(ra(1, `R_STS), 32'h8);
    w8();
    chk({31'h0, general_fault_flag}, 32'h0);
    wr(ra(1, `R_LOAD), 32'd6);
    ctl(1, 32'h2);
    w8();
    rc(1, `R_COUNT, 32'd6);
    chk({31'h0, general_fault_flag}, 32'h1);
    done("fault");
    ctl(3, 32'h1);
    enc_src_inst.pulse(3, 1'b1, 2, 36);
    w8();
    apb(1'b0, ra(3, `R_SPACE), 32'h0);
    chk({31'h0, q >= 32'd9 && q <= 32'd11}, 32'h1);
    done("spacing");
    stop_test();
  end
endmodule : tb_encoder_count_core
`default_nettype wire
